//--- logic/vdet_defs.svh
`ifndef VDET_DEFS_SVH
`define VDET_DEFS_SVH
// Register addresses on the CPU bus
`define VDET_CTRL_ADDR 20'hfffa9
`define VDET_LEVEL_ADDR 20'hfffaa
// Option byte locations
`define VDET_OPT_ADDR 20'h000c1
`define VDET_OPT_SWAP_ADDR 20'h010c1
// Control register fields
`define VDET_CTRL_EN_BIT 7
`define VDET_CTRL_MSK_BIT 1
`define VDET_CTRL_FLAG_BIT 0
`define VDET_CTRL_RST 8'h00
`define VDET_CTRL_EN_RST 1'b0
// Level register fields
`define VDET_LVL_MODE_BIT 7
`define VDET_LVL_SEL_BIT 0
`define VDET_LVL_RST_IR 8'h00
`define VDET_LVL_RST_R 8'h81
`define VDET_LVL_RST_I 8'h01
// Option byte mode field codes
`define VDET_OPT_IR 2'h2
`define VDET_OPT_R 2'h3
`define VDET_OPT_I 2'h1
// Option byte field positions
`define VDET_OPT_MODE_HI 1
`define VDET_OPT_MODE_LO 0
`define VDET_OPT_LOW_HI 7
`define VDET_OPT_LOW_LO 5
// Settle time after a level change, ns, and derived cycle count (10 ns clock)
`define VDET_SETTLE_NS 300
`define VDET_CLK_NS 10
`define VDET_SETTLE_CYC (`VDET_SETTLE_NS / `VDET_CLK_NS)
// Largest count the eight-bit settle counter holds
`define VDET_SETTLE_MAX 255
`endif

//--- logic/vdet_pkg.sv
package vdet_pkg;
  // Detector operating mode decoded from the option byte
  typedef enum logic [1:0] {
    mode_off_t_e,
    mode_int_e,
    mode_irst_e,
    mode_rst_e
  } det_mode_t;
endpackage : vdet_pkg

//--- logic/vdet_sync_if.sv
// Carries the synchronised comparator level to the main logic
interface vdet_sync_if;
  logic below;
  modport src (output below);
  modport dst (input below);
endinterface : vdet_sync_if

//--- logic/vdet_sync.sv
`include "vdet_defs.svh"
module vdet_sync #(
  parameter int STAGES = 2
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_async,
  vdet_sync_if.src o_sync
);
  // Elaboration check: a proper crossing needs two stages at least
  if (STAGES < 2) begin : g_chk
    $error("vdet_sync needs at least two stages");
  end
  logic [STAGES-1:0] chain_q;
  logic [STAGES-1:0] chain_d;
  // Shift chain; only the next stage reads the first flop
  always_comb begin
    chain_d = {chain_q[STAGES-2:0], i_async};
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      chain_q <= '0;
    end else begin
      chain_q <= chain_d;
    end
  end
  assign o_sync.below = chain_q[STAGES-1];
endmodule : vdet_sync

//--- logic/voltage_detector_control.sv
`include "vdet_defs.svh"
module voltage_detector_control #(
  parameter int SETTLE_CYC = `VDET_SETTLE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,          // Any reset, synchronous
  input wire logic i_det_reset,     // High when the reset came from this detector
  input wire logic [7:0] i_opt,     // Option byte at its fixed location
  input wire logic i_cmp_high,      // Comparator: supply below high threshold
  input wire logic i_cmp_low,       // Comparator: supply below low/single threshold
  input wire logic [19:0] i_addr,   // CPU bus address
  input wire logic i_wr,            // CPU write strobe
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic [7:0] o_high_sel,    // Picks high threshold: VPOC and pair fields
  output logic [7:0] o_low_sel,     // Picks low threshold
  output logic o_low_level_sel,     // Comparator level currently watched
  output logic o_undervoltage_irq,  // One-cycle interrupt pulse
  output logic o_detector_reset     // Internal reset request
);
  // Settle counter is eight bits wide; a zero wait would never mask
  if (SETTLE_CYC < 1 || SETTLE_CYC > `VDET_SETTLE_MAX) begin : g_chk
    $error("SETTLE_CYC must lie between one and 255");
  end
  // Synchronised comparator levels
  vdet_sync_if s_hi ();
  vdet_sync_if s_lo ();
  vdet_sync #(.STAGES(2)) u_sync_hi (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_async(i_cmp_high), .o_sync(s_hi));
  vdet_sync #(.STAGES(2)) u_sync_lo (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_async(i_cmp_low), .o_sync(s_lo));

  // Mode decode from the option byte only
  vdet_pkg::det_mode_t mode;
  always_comb begin
    case (i_opt[`VDET_OPT_MODE_HI:`VDET_OPT_MODE_LO])
      `VDET_OPT_IR: mode = vdet_pkg::mode_irst_e;
      `VDET_OPT_R: mode = vdet_pkg::mode_rst_e;
      `VDET_OPT_I: mode = vdet_pkg::mode_int_e;
      default: mode = vdet_pkg::mode_off_t_e;
    endcase
  end
  // Combined interrupt and reset mode; only here does the mask exist
  logic irst;
  assign irst = (mode == vdet_pkg::mode_irst_e);
  // Threshold select: the analog picks by these fields; bad combos are the user's
  assign o_high_sel = i_opt;
  assign o_low_sel = {i_opt[`VDET_OPT_LOW_HI:`VDET_OPT_LOW_LO], 5'h00};

  // Register state
  logic en_q, en_d;         // Rewrite enable
  logic mode_q, mode_d;     // Level reg mode bit
  logic sel_q, sel_d;       // Level reg select bit
  logic [7:0] settle_q, settle_d; // Settling wait counter
  logic below_q, below_d;   // Previous watched level, for edges
  logic irq_q, irq_d;
  logic rst_q, rst_d;
  logic below;              // Supply below watched level
  logic mask;
  logic wr_ctrl, wr_lvl;

  // Write decode; each bus write lasts one cycle
  assign wr_ctrl = i_wr && (i_addr == `VDET_CTRL_ADDR);
  assign wr_lvl = i_wr && (i_addr == `VDET_LEVEL_ADDR);
  // Watched level: zero with the detector off, else low comparator whenever select is one
  assign below = (mode == vdet_pkg::mode_off_t_e) ? 1'b0 :
                 (sel_q ? s_lo.below : s_hi.below);
  // Mask only exists in the combined mode
  assign mask = irst && (en_q || settle_q != 8'h00);

  // Next-state logic
  always_comb begin
    en_d = en_q;
    mode_d = mode_q;
    sel_d = sel_q;
    settle_d = (settle_q != 8'h00) ? settle_q - 8'h01 : 8'h00;
    below_d = below;
    irq_d = 1'b0;
    rst_d = 1'b0;
    if (wr_ctrl) begin
      en_d = i_wdata[`VDET_CTRL_EN_BIT];
    end
    if (wr_lvl && en_q) begin
      mode_d = i_wdata[`VDET_LVL_MODE_BIT];
      sel_d = i_wdata[`VDET_LVL_SEL_BIT];
      if (i_wdata[`VDET_LVL_SEL_BIT] != sel_q) begin
        settle_d = SETTLE_CYC[7:0];
      end
    end
    case (mode)
      vdet_pkg::mode_irst_e: begin
        // Falling through high level: interrupt once, then watch low
        if (!mask && !sel_q && below && !below_q) begin
          irq_d = 1'b1;
          mode_d = 1'b1;
          sel_d = 1'b1;
          settle_d = SETTLE_CYC[7:0];
        end
        rst_d = !mask && s_lo.below;
      end
      vdet_pkg::mode_rst_e: rst_d = below;
      vdet_pkg::mode_int_e: irq_d = (below != below_q);
      default: begin
        irq_d = 1'b0;
      end
    endcase
  end

  // Registers: detector reset holds enable and level bits, others load defaults; every reset clears the rest
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      if (!i_det_reset) begin
        en_q <= `VDET_CTRL_EN_RST;
        mode_q <= (i_opt[`VDET_OPT_MODE_HI:`VDET_OPT_MODE_LO] == `VDET_OPT_R);
        sel_q <= (i_opt[`VDET_OPT_MODE_HI:`VDET_OPT_MODE_LO] != `VDET_OPT_IR);
      end
      settle_q <= 8'h00;
      below_q <= 1'b0;
      irq_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      en_q <= en_d;
      mode_q <= mode_d;
      sel_q <= sel_d;
      settle_q <= settle_d;
      below_q <= below_d;
      irq_q <= irq_d;
      rst_q <= rst_d;
    end
  end

  // Read mux; flag and mask bits are hardware state only
  always_comb begin
    o_rdata = 8'h00;
    if (i_addr == `VDET_CTRL_ADDR) begin
      o_rdata[`VDET_CTRL_EN_BIT] = en_q;
      o_rdata[`VDET_CTRL_MSK_BIT] = mask;
      o_rdata[`VDET_CTRL_FLAG_BIT] = below;
    end else if (i_addr == `VDET_LEVEL_ADDR) begin
      o_rdata[`VDET_LVL_MODE_BIT] = mode_q;
      o_rdata[`VDET_LVL_SEL_BIT] = sel_q;
    end else if (i_addr == `VDET_OPT_ADDR) begin
      o_rdata = i_opt;
    end
  end
  // Outputs come straight from state flops
  assign o_low_level_sel = sel_q;
  assign o_undervoltage_irq = irq_q;
  assign o_detector_reset = rst_q;

  // Checks
  // A control write with enable low must not raise the mask by itself
  property p_ro_flags;
    @(posedge i_clk) disable iff (!i_rstn)
      (wr_ctrl && !en_q && settle_q == 8'h00 && !irq_d && !i_wdata[`VDET_CTRL_EN_BIT])
      |=> !mask;
  endproperty
  a_ro_flags: assert property (p_ro_flags) else $error("mask flag not hardware driven");
  property p_lvl_gate;
    @(posedge i_clk) disable iff (!i_rstn)
      (wr_lvl && !en_q && !irq_d) |=> $stable(sel_q);
  endproperty
  a_lvl_gate: assert property (p_lvl_gate) else $error("level written while locked");
  property p_mask_mode;
    @(posedge i_clk) disable iff (!i_rstn) !irst |-> !mask;
  endproperty
  a_mask_mode: assert property (p_mask_mode) else $error("mask outside combined mode");
  property p_irq_bits;
    @(posedge i_clk) disable iff (!i_rstn)
      (irst && $rose(irq_q)) |-> (sel_q && mode_q);
  endproperty
  a_irq_bits: assert property (p_irq_bits) else $error("level bits not set by irq");
  property p_rst_mode;
    @(posedge i_clk) disable iff (!i_rstn)
      (mode == vdet_pkg::mode_rst_e && $stable(mode)) |=> (rst_q == $past(below));
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("reset mode mismatch");
  // Interrupt must start the settle wait, so the mask stands at once
  property p_settle_mask;
    @(posedge i_clk) disable iff (!i_rstn) (irst && $rose(irq_q)) |-> mask;
  endproperty
  a_settle_mask: assert property (p_settle_mask) else $error("mask not set after irq");
  property p_flag;
    @(posedge i_clk) disable iff (!i_rstn)
      (mode == vdet_pkg::mode_off_t_e) |-> !below;
  endproperty
  a_flag: assert property (p_flag) else $error("flag set with detector off");
  property p_ctrl_rst;
    @(posedge i_clk) (!i_rstn && !i_det_reset) |=> !en_q;
  endproperty
  a_ctrl_rst: assert property (p_ctrl_rst) else $error("enable not cleared");
  property p_keep;
    @(posedge i_clk) (!i_rstn && i_det_reset) |=> $stable(sel_q) && $stable(en_q);
  endproperty
  a_keep: assert property (p_keep) else $error("detector reset lost contents");
  // Other resets load level bits from the option mode field
  property p_lvl_rst;
    @(posedge i_clk) (!i_rstn && !i_det_reset) |=>
      (sel_q == ($past(i_opt[`VDET_OPT_MODE_HI:`VDET_OPT_MODE_LO]) != `VDET_OPT_IR)) &&
      (mode_q == ($past(i_opt[`VDET_OPT_MODE_HI:`VDET_OPT_MODE_LO]) == `VDET_OPT_R));
  endproperty
  a_lvl_rst: assert property (p_lvl_rst) else $error("level reset value wrong");
endmodule : voltage_detector_control

//--- sim/vdet_supply_model.sv
// Analog comparator pair seen from the supply rail
module vdet_supply_model (
  input wire logic [1:0] i_supply,  // 0 above both, 1 between, 2 below both
  output logic o_cmp_high,
  output logic o_cmp_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // Low threshold sits under high, so below low implies below high
  always_comb begin
    o_cmp_high = (i_supply != 2'h0);
    o_cmp_low = (i_supply == 2'h2);
  end
endmodule : vdet_supply_model

//--- sim/test_voltage_detector_control.sv
module test_voltage_detector_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_det_reset = 1'b0, i_wr = 1'b0;
  logic [7:0] i_opt = 8'h1a, i_wdata = 8'h00;
  logic [19:0] i_addr = 20'h00000;
  logic [1:0] supply = 2'h0;  // Rail level handed to the model
  logic cmp_high, cmp_low, irq, det_rst;
  logic [7:0] rdata, hsel, lsel;
  logic lvl_sel;  // Level select bit seen at the pin
  int error_cnt = 0, n_tests = 0, cyc = 0;
  always #5 i_clk = ~i_clk;
  vdet_supply_model sup_u (.i_supply(supply), .o_cmp_high(cmp_high), .o_cmp_low(cmp_low));
  // Short settle keeps the run brief
  voltage_detector_control #(.SETTLE_CYC(2)) dut_u (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_det_reset(i_det_reset), .i_opt(i_opt), .i_cmp_high(cmp_high), .i_cmp_low(cmp_low),
    .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(rdata), .o_high_sel(hsel),
    .o_low_sel(lsel), .o_low_level_sel(lvl_sel), .o_undervoltage_irq(irq),
    .o_detector_reset(det_rst));
  // Generic comparison of one result
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Comparison of one event or single-bit level
  task automatic chk_evt(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_evt
  task automatic final_report;
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // Hang guard, tests need well under 1000 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end
  // Reset with a chosen source; option byte is static across it
  task automatic do_reset(input logic [7:0] opt, input logic det, input int n);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    i_det_reset <= det;
    i_opt <= opt;
    repeat (n) @(posedge i_clk);
    i_rstn <= 1'b1;
    i_det_reset <= 1'b0;
  endtask : do_reset
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // Combinational read, sampled once settled
  task automatic rd(input logic [19:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    #1 d = rdata;
  endtask : rd
  // Bounded wait for a one-cycle pulse or a level
  task automatic wait_hi(input bit want_rst, input int lim, output logic seen);
    seen = 1'b0;
    for (int k = 0; k < lim && !seen; k++) begin
      @(posedge i_clk);
      #1 seen = want_rst ? det_rst : irq;
    end
  endtask : wait_hi
  // Level reset values for the combined, reset and interrupt option modes, control cleared
  task automatic t_reset_values;
    logic [7:0] opts [3] = '{8'h5a, 8'h1f, 8'h1d};
    logic [7:0] exps [3] = '{8'h00, 8'h81, 8'h01};
    logic [7:0] d;
    foreach (opts[i]) begin
      do_reset(opts[i], 1'b0, 2);
      rd(20'hfffaa, d);
      chk("level", exps[i], d);
      chk("high sel", opts[i], hsel);
      chk("low sel", {opts[i][7:5], 5'h00}, lsel);
      chk_evt("level sel", exps[i][0], lvl_sel);
      rd(20'hfffa9, d);
      chk("ctrl", 8'h00, d);
    end
    $display("Test reset values done");
  endtask : t_reset_values
  // Enable gating, read-only flags, detector reset holding both
  task automatic t_gate_hold;
    logic [7:0] d;
    do_reset(8'h1a, 1'b0, 2);
    wr(20'hfffaa, 8'h01);
    rd(20'hfffaa, d);
    chk("level locked", 8'h00, d);
    wr(20'hfffa9, 8'h03);
    rd(20'hfffa9, d);
    chk("ctrl flags read only", 8'h00, d);
    wr(20'hfffa9, 8'hff);
    rd(20'hfffa9, d);
    chk("ctrl enabled", 8'h82, d);
    wr(20'hfffaa, 8'h01);
    rd(20'hfffaa, d);
    chk("level written", 8'h01, d);
    do_reset(8'h1a, 1'b1, 2);
    rd(20'hfffa9, d);
    chk("ctrl held", 8'h82, d);
    rd(20'hfffaa, d);
    chk("level held", 8'h01, d);
    $display("Test gate and hold done");
  endtask : t_gate_hold
  // Falling supply in combined mode: interrupt, then internal reset
  task automatic t_combined;
    logic [7:0] d;
    logic s;
    do_reset(8'h1a, 1'b0, 2);
    supply <= 2'h1;
    wait_hi(1'b0, 8, s);
    chk_evt("irq", 1'b1, s);
    rd(20'hfffa9, d);
    chk("mask settling", 8'h02, d);
    repeat (4) @(posedge i_clk);
    rd(20'hfffaa, d);
    chk("level after irq", 8'h81, d);
    supply <= 2'h2;
    wait_hi(1'b1, 12, s);
    chk_evt("detector reset", 1'b1, s);
    supply <= 2'h0;
    $display("Test combined mode done");
  endtask : t_combined
  // Interrupt-only mode: flag follows rail, irq on each crossing
  task automatic t_int_mode;
    logic [7:0] d;
    logic s;
    do_reset(8'h1d, 1'b0, 2);
    supply <= 2'h2;
    wait_hi(1'b0, 8, s);
    chk_evt("irq falling", 1'b1, s);
    rd(20'hfffa9, d);
    chk("flag below", 8'h01, d);
    supply <= 2'h0;
    wait_hi(1'b0, 8, s);
    chk_evt("irq rising", 1'b1, s);
    rd(20'hfffa9, d);
    chk("flag above", 8'h00, d);
    // Reset mode: low rail raises the internal reset
    do_reset(8'h1f, 1'b0, 2);
    supply <= 2'h2;
    wait_hi(1'b1, 8, s);
    chk_evt("reset mode reset", 1'b1, s);
    // Detector off: no interrupt, flag stays low
    do_reset(8'h1c, 1'b0, 2);
    wait_hi(1'b0, 8, s);
    chk_evt("irq off", 1'b0, s);
    rd(20'hfffa9, d);
    chk("flag off", 8'h00, d);
    supply <= 2'h0;
    $display("Test interrupt mode done");
  endtask : t_int_mode
  initial begin
    do_reset(8'h1a, 1'b0, 6);
    t_reset_values();
    t_gate_hold();
    t_combined();
    t_int_mode();
    final_report();
  end
endmodule : test_voltage_detector_control
